// *** src/clock_reset_boot_map.svh ***
// Constants for the clock, reset and boot-start block.
// Assumes inclusion by its bare name from design files only.
`ifndef CLOCK_RESET_BOOT_MAP_SVH
`define CLOCK_RESET_BOOT_MAP_SVH

// Register offsets on the plain register port
`define OFF_PLL_CTL      4'h0
`define OFF_BOOT_STAT    4'h1
`define OFF_SW_RESET     4'h2
`define OFF_STATUS       4'h3

// Field positions of the PLL control register
`define PLL_MSEL_LSB     0
`define PLL_MSEL_MSB     6
`define PLL_RANGE_BIT    7
`define PLL_BYPASS_BIT   8
`define PLL_HALF_BIT     9

// Reset values
`define PLL_HALF_RST     1'b0
`define BOOT_MODE_RST    3'h0

// Synchroniser reset levels, reset pin inactive high
`define SYNC_RST_LEVELS  16'h1000

// Boot ROM start address
`define BOOT_ROM_ADDR    24'hFF0000

// Software reset key, value is arbitrary
`define SW_RESET_KEY     16'h00A5

// Power-on hold time in input clock cycles
`define POR_HOLD_CYC     512

`endif

// *** src/clock_reset_boot_pkg.sv ***
// Types for the clock, reset and boot-start block.
// Assumes no other package.
package clock_reset_boot_pkg;

    // Boot source selected by the strap pins
    typedef enum logic [2:0] {
        BOOT_RSVD0   = 3'h0,
        BOOT_EXT8    = 3'h1,
        BOOT_EXEC8   = 3'h2,
        BOOT_EXEC16  = 3'h3,
        BOOT_SPI_SML = 3'h4,
        BOOT_SPI_BIG = 3'h5,
        BOOT_RSVD6   = 3'h6,
        BOOT_RSVD7   = 3'h7
    } boot_mode_t;

    // Reset sequencer states
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_BOOT,
        ST_RUN
    } seq_state_t;

endpackage

// *** src/clock_reset_boot_select.sv ***
// Clock configuration, master reset and boot-start sequencer.
// Assumes one 50 MHz clock, synchronous active-high reset, and
// pins from the board that are asynchronous to clk_sys_in.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`include "clock_reset_boot_map.svh"

// Notes on behaviour
// - Multiplier select spans 128 ratios
// - Factor loaded at reset, software may change
// - Peripheral clock driven on output pin
// - Peripheral clock is core or half
// - Low reset pin resets whole device
// - Power-on reset output during power-up, brownout
// - Master reset empties stacks, masks, defaults
// - Release with no bus request jumps ROM
// - Pin or software reset raises boot interrupt
// - Always start at boot ROM
// - Boot pins sampled only at hardware reset
// - Codes 1 to 3 external memory
// - Codes 4 and 5 serial memory
module clock_reset_boot_select #(
    parameter int POR_HOLD = `POR_HOLD_CYC  // Power-on hold count
) (
    input  wire logic        clk_sys_in,          // System clock
    input  wire logic        srst_in,             // Sync reset
    input  wire logic        reset_n_in,          // Reset pin, low
    input  wire logic        supply_low_in,       // Brownout detect
    input  wire logic        bypass_in,           // PLL bypass pin
    input  wire logic [6:0]  pll_multiplier_select_in, // Strap
    input  wire logic        input_range_bit_in,  // Strap
    input  wire logic        boot_select_bit2_in, // Boot strap
    input  wire logic        boot_select_bit1_in, // Boot strap
    input  wire logic        boot_select_bit0_in, // Boot strap
    input  wire logic        bus_request_in,      // Bus request
    input  wire logic        core_clock_in,       // Core clock level
    input  wire logic [3:0]  addr_in,             // Register address
    input  wire logic [15:0] wdata_in,            // Write data
    input  wire logic        wr_in,               // Write strobe
    input  wire logic        rd_in,               // Read strobe
    output logic [15:0]      rdata_out,           // Read data
    output logic             por_n_out,           // Power-on reset
    output logic             master_reset_out,    // Chip reset
    output logic             boot_irq_out,        // Boot NMI pulse
    output logic [23:0]      boot_vector_out,     // Fetch address
    output logic [2:0]       boot_mode_out,       // Captured mode
    output logic             boot_mode_bad_out,   // Reserved code
    output logic [6:0]       pll_multiplier_select_out, // Factor
    output logic             input_range_bit_out, // Range bit
    output logic             pll_bypass_out,      // Bypass
    output logic             peripheral_clock_out_pin_out // Clock out
);

    // =========================================================
    // Input synchronisers
    // =========================================================
    // Bundle layout, low bit first:
    //   [6:0]  multiplier strap
    //   [7]    bypass strap
    //   [8]    range strap
    //   [11:9] boot straps, bit 2 highest
    //   [12]   reset pin, low active
    //   [13]   brownout detect
    //   [14]   bus request
    //   [15]   core clock level
    // Every pin is asynchronous to the system clock, so none of
    // them is read before the second stage.
    localparam int NSYNC = 16;          // Synchronised pin count
    logic [NSYNC-1:0] pin_raw;          // Raw pin bundle
    logic [NSYNC-1:0] sync1_ff;         // First stage
    logic [NSYNC-1:0] sync2_ff;         // Second stage

    assign pin_raw = {core_clock_in, bus_request_in, supply_low_in,
                      reset_n_in, boot_select_bit2_in,
                      boot_select_bit1_in, boot_select_bit0_in,
                      input_range_bit_in, bypass_in,
                      pll_multiplier_select_in};

    // Two flops per pin, reset to inactive levels
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            sync1_ff <= `SYNC_RST_LEVELS;
            sync2_ff <= `SYNC_RST_LEVELS;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
        end
    end

    // Named views of the second stage
    logic       rst_pin_n_s;   // Reset pin level
    logic       supply_low_s;  // Brownout level
    logic       bus_req_s;     // Bus request level
    logic       core_clk_s;    // Core clock level
    logic [2:0] boot_pins_s;   // Boot straps
    logic [6:0] msel_s;        // Multiplier strap
    logic       range_s;       // Range strap
    logic       bypass_s;      // Bypass strap

    assign msel_s       = sync2_ff[6:0];
    assign bypass_s     = sync2_ff[7];
    assign range_s      = sync2_ff[8];
    assign boot_pins_s  = sync2_ff[11:9];
    assign rst_pin_n_s  = sync2_ff[12];
    assign supply_low_s = sync2_ff[13];
    assign bus_req_s    = sync2_ff[14];
    assign core_clk_s   = sync2_ff[15];

    // =========================================================
    // Power-on reset generator
    // =========================================================
    localparam int PCW = $clog2(POR_HOLD + 1); // Counter width
    logic [PCW-1:0] por_cnt_ff;                // Hold counter

    // The counter stands in for the on-chip supervisor: it holds the
    // output low for the hold time after reset or a supply drop, so
    // a board that ties the output to the reset pin needs nothing
    // else. The count saturates and stays there until restarted.
    // Restart on brownout, count up to the hold time
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || supply_low_s) begin
            por_cnt_ff <= '0;
        end else if (por_cnt_ff != PCW'(POR_HOLD)) begin
            por_cnt_ff <= por_cnt_ff + PCW'(1);
        end
    end

    // Output low while counting or supply is low
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            por_n_out <= 1'b0;
        end else begin
            por_n_out <= (por_cnt_ff == PCW'(POR_HOLD))
                         && !supply_low_s;
        end
    end

    // =========================================================
    // Reset sequencer
    // =========================================================
    clock_reset_boot_pkg::seq_state_t state_ff; // Sequencer state
    logic sw_reset_ff;                           // Software reset req
    logic hw_rst;                                // Pin reset active

    assign hw_rst = !rst_pin_n_s;

    // Flow: HOLD while the pin reset is low or a bus request is
    // pending, one BOOT cycle that fires the boot interrupt, then
    // RUN. A software reset key returns to HOLD without sampling
    // the boot straps again, so the captured mode survives it.
    // A bus master that never lets go keeps the core parked here.
    // Hold, then boot when no bus request, then run
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || hw_rst) begin
            state_ff <= clock_reset_boot_pkg::ST_HOLD;
        end else begin
            unique case (state_ff)
                clock_reset_boot_pkg::ST_HOLD: begin
                    // Wait for bus request to clear
                    if (!bus_req_s) begin
                        state_ff <= clock_reset_boot_pkg::ST_BOOT;
                    end
                end
                clock_reset_boot_pkg::ST_BOOT: begin
                    state_ff <= clock_reset_boot_pkg::ST_RUN;
                end
                clock_reset_boot_pkg::ST_RUN: begin
                    // Software reset re-enters hold
                    if (sw_reset_ff) begin
                        state_ff <= clock_reset_boot_pkg::ST_HOLD;
                    end
                end
            endcase
        end
    end

    // Master reset while held; it also follows the pin directly so
    // that it rises on the same edge that takes the sequencer out of run
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            master_reset_out <= 1'b1;
        end else begin
            master_reset_out <= hw_rst ||
                (state_ff == clock_reset_boot_pkg::ST_HOLD);
        end
    end

    // Boot interrupt pulse and ROM vector
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            boot_irq_out    <= 1'b0;
            boot_vector_out <= `BOOT_ROM_ADDR;
        end else begin
            boot_irq_out <= !hw_rst &&
                (state_ff == clock_reset_boot_pkg::ST_BOOT);
            boot_vector_out <= `BOOT_ROM_ADDR;
        end
    end

    // =========================================================
    // Boot mode capture
    // =========================================================
    // Sampled only while the pin reset is active; held through
    // software resets and through strap changes while running
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            boot_mode_out <= `BOOT_MODE_RST;
        end else if (hw_rst) begin
            boot_mode_out <= boot_pins_s;
        end
    end

    // Flag reserved codes; valid are 1 to 5. Decoded from the same
    // strap sample as the mode, so flag and mode never disagree
    // for a cycle after a capture.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            boot_mode_bad_out <= 1'b1;
        end else if (hw_rst) begin
            unique case (clock_reset_boot_pkg::boot_mode_t'(boot_pins_s))
                clock_reset_boot_pkg::BOOT_EXT8,
                clock_reset_boot_pkg::BOOT_EXEC8,
                clock_reset_boot_pkg::BOOT_EXEC16:
                    boot_mode_bad_out <= 1'b0;
                clock_reset_boot_pkg::BOOT_SPI_SML,
                clock_reset_boot_pkg::BOOT_SPI_BIG:
                    boot_mode_bad_out <= 1'b0;
                default:
                    boot_mode_bad_out <= 1'b1;
            endcase
        end
    end

    // =========================================================
    // PLL control register
    // =========================================================
    logic wr_pll; // Write to PLL control
    assign wr_pll = wr_in && (addr_in == `OFF_PLL_CTL);

    // Register layout: multiplier in the low seven bits, then the
    // range bit, the bypass bit and the half-rate select. Software
    // must keep the range bit matched to the input clock; the block
    // only stores it. Writes are ignored while the pin reset holds
    // the straps in.
    // Straps load during pin reset, software writes later
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            pll_multiplier_select_out <= '0;
            input_range_bit_out       <= 1'b0;
            pll_bypass_out            <= 1'b0;
        end else if (hw_rst) begin
            pll_multiplier_select_out <= msel_s;
            input_range_bit_out       <= range_s;
            pll_bypass_out            <= bypass_s;
        end else if (wr_pll) begin
            pll_multiplier_select_out <=
                wdata_in[`PLL_MSEL_MSB:`PLL_MSEL_LSB];
            input_range_bit_out <= wdata_in[`PLL_RANGE_BIT];
            pll_bypass_out      <= wdata_in[`PLL_BYPASS_BIT];
        end
    end

    logic half_sel_ff; // Peripheral half-rate select
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || hw_rst) begin
            half_sel_ff <= `PLL_HALF_RST;
        end else if (wr_pll) begin
            half_sel_ff <= wdata_in[`PLL_HALF_BIT];
        end
    end

    // Software reset request, one cycle
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            sw_reset_ff <= 1'b0;
        end else begin
            sw_reset_ff <= wr_in && (addr_in == `OFF_SW_RESET)
                           && (wdata_in == `SW_RESET_KEY);
        end
    end

    // =========================================================
    // Peripheral clock
    // =========================================================
    // The core clock arrives as a sampled level, so the half-rate
    // output toggles once per rising sample. It is only as exact as
    // that sampling; a core clock near the system rate will alias.
    // The half-rate select is cleared by a pin reset.
    logic core_prev_ff; // Previous core level
    logic half_tog_ff;  // Divide-by-two toggle
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            core_prev_ff <= 1'b0;
            half_tog_ff  <= 1'b0;
        end else begin
            core_prev_ff <= core_clk_s;
            if (core_clk_s && !core_prev_ff) begin
                half_tog_ff <= !half_tog_ff;
            end
        end
    end

    // Core or half rate onto the pin
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            peripheral_clock_out_pin_out <= 1'b0;
        end else begin
            peripheral_clock_out_pin_out <=
                half_sel_ff ? half_tog_ff : core_clk_s;
        end
    end

    // =========================================================
    // Register read port
    // =========================================================
    // Read data stand for one cycle after the strobe, and are zero
    // otherwise so a bus that ORs slaves together stays clean.
    // Offset 2 is write-only and reads as zero like unmapped ones.
    // Status holds the power-on reset level, the master reset and
    // a running flag in its low three bits.
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            unique case (addr_in)
                `OFF_PLL_CTL:   rdata_out <= {6'h00, half_sel_ff,
                    pll_bypass_out, input_range_bit_out,
                    pll_multiplier_select_out};
                `OFF_BOOT_STAT: rdata_out <= {12'h000,
                    boot_mode_bad_out, boot_mode_out};
                `OFF_STATUS:    rdata_out <= {13'h0000, por_n_out,
                    master_reset_out, state_ff ==
                    clock_reset_boot_pkg::ST_RUN};
                default:        rdata_out <= 16'h0000;
            endcase
        end else begin
            rdata_out <= 16'h0000;
        end
    end

endmodule

// *** test/clock_reset_boot_select_assertions.sv ***
// Checker for the clock, reset and boot-start block.
// Assumes a bind onto the top module and slowly moving straps.
`timescale 1ns/1ps
module crbs_checker #(
    parameter int POR_HOLD = 512  // Power-on hold count
) (
    input wire logic        clk_sys_in,
    input wire logic        srst_in,
    input wire logic        reset_n_in,
    input wire logic        supply_low_in,
    input wire logic        bus_request_in,
    input wire logic [6:0]  pll_multiplier_select_in,
    input wire logic        boot_select_bit2_in,
    input wire logic        boot_select_bit1_in,
    input wire logic        boot_select_bit0_in,
    input wire logic        por_n_out,
    input wire logic        master_reset_out,
    input wire logic        boot_irq_out,
    input wire logic [23:0] boot_vector_out,
    input wire logic [2:0]  boot_mode_out,
    input wire logic        boot_mode_bad_out,
    input wire logic [6:0]  pll_multiplier_select_out
);
    // ==========================================================
    // Helper logic
    int         low_cnt_ff;  // Cycles spent with power-on reset low
    logic [2:0] pins;        // Boot straps as one code

    assign pins = {boot_select_bit2_in, boot_select_bit1_in,
                   boot_select_bit0_in};

    // Count power-on reset low time
    always_ff @(posedge clk_sys_in) begin
        if (srst_in || por_n_out)
            low_cnt_ff <= 0;
        else
            low_cnt_ff <= low_cnt_ff + 1;
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    a_vector_fixed: assert property (
        boot_vector_out == 24'hFF0000) else $error("boot vector moved");
    a_bad_code: assert property (
        boot_mode_bad_out == (boot_mode_out inside {3'h0, 3'h6, 3'h7}))
        else $error("reserved flag wrong");
    a_mode_hold: assert property (
        reset_n_in [*6] |-> $stable(boot_mode_out))
        else $error("boot mode moved without reset");
    a_mode_capture: assert property (
        (!reset_n_in && $stable(pins)) [*6] |-> boot_mode_out == pins)
        else $error("boot straps not captured");
    a_pll_capture: assert property (
        (!reset_n_in && $stable(pll_multiplier_select_in)) [*6]
        |-> pll_multiplier_select_out == pll_multiplier_select_in)
        else $error("multiplier strap not captured");
    a_pin_reset: assert property (
        (!reset_n_in) [*3] |-> ##[0:4] master_reset_out)
        else $error("reset pin ignored");
    a_irq_pulse: assert property (
        boot_irq_out |=> !boot_irq_out) else $error("boot irq too long");
    a_bus_blocks: assert property (
        bus_request_in [*6] |-> !boot_irq_out)
        else $error("boot with bus request pending");
    a_brownout: assert property (
        supply_low_in [*3] |-> ##[0:3] !por_n_out)
        else $error("supply drop ignored");
    a_por_length: assert property (
        $rose(por_n_out) |-> low_cnt_ff >= POR_HOLD)
        else $error("power-on reset too short");

    c_boot: cover property (boot_irq_out);
    c_por: cover property ($rose(por_n_out));
    c_bad: cover property (boot_mode_bad_out ##1 !boot_mode_bad_out);
endmodule

bind clock_reset_boot_select crbs_checker #(.POR_HOLD(POR_HOLD)) chk_u (
    .clk_sys_in, .srst_in, .reset_n_in, .supply_low_in, .bus_request_in,
    .pll_multiplier_select_in, .boot_select_bit2_in, .boot_select_bit1_in,
    .boot_select_bit0_in, .por_n_out, .master_reset_out, .boot_irq_out,
    .boot_vector_out, .boot_mode_out, .boot_mode_bad_out,
    .pll_multiplier_select_out
);

// *** test/board_model.sv ***
// Board model: reset source, oscillator and boot straps.
// Assumes one clock shared with the block under test.
`timescale 1ns/1ps
module board_model #(
    parameter int HOLD = 512  // Reset frame length in cycles
) (
    input  wire logic       clk_in,        // Board clock
    input  wire logic       rst_req_in,    // Start a reset frame
    input  wire logic [2:0] code_in,       // Boot code to strap
    input  wire logic [6:0] msel_in,       // Multiplier to strap
    input  wire logic       fast_in,       // Input clock above 100 MHz
    output logic            reset_n_out,   // Reset pin, low active
    output logic            core_clk_out,  // Core clock level
    output logic [2:0]      boot_pins_out, // Boot straps
    output logic [6:0]      msel_out,      // Multiplier straps
    output logic            range_out      // Range strap
);
    // ==========================================================
    // Reset frame and oscillator
    int   hold_ff = 0;     // Cycles left with reset low
    logic core_ff = 1'b0;  // Core clock level

    // Hold reset low for the whole frame
    always_ff @(posedge clk_in) begin
        if (rst_req_in)
            hold_ff <= HOLD;
        else if (hold_ff != 0)
            hold_ff <= hold_ff - 1;
    end
    assign reset_n_out = (hold_ff == 0);

    // Oscillator never stops or changes rate
    always_ff @(posedge clk_in) begin
        core_ff <= ~core_ff;
    end
    assign core_clk_out  = core_ff;
    assign range_out     = fast_in;
    assign msel_out      = msel_in;
    assign boot_pins_out = code_in;
endmodule

// *** test/test_clock_reset_boot_select.sv ***
// Testbench for the clock, reset and boot-start block.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps
module test_clock_reset_boot_select;
    // ==========================================================
    // Signals
    logic        clk_sys_in = 0;
    logic        srst_in = 1;
    logic        supply_low_in = 0;
    logic        bypass_in = 0;
    logic        bus_request_in = 0;
    logic [3:0]  addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in = 0;
    logic        rd_in = 0;
    logic        rst_req = 0;  // Ask the board for a reset frame
    logic [2:0]  code = 3'h0;  // Boot code on the straps
    logic [6:0]  msel = 7'h00; // Multiplier on the straps
    logic        fast = 0;     // Input clock above 100 MHz
    logic        reset_n_in, core_clock_in, input_range_bit_in;
    logic        boot_select_bit2_in, boot_select_bit1_in;
    logic        boot_select_bit0_in, por_n_out, master_reset_out;
    logic        boot_irq_out, boot_mode_bad_out, input_range_bit_out;
    logic        pll_bypass_out, peripheral_clock_out_pin_out;
    logic [6:0]  pll_multiplier_select_in, pll_multiplier_select_out;
    logic [15:0] rdata_out;
    logic [23:0] boot_vector_out;
    logic [2:0]  boot_mode_out;
    int          num_errors = 0;
    int          n_compared = 0;

    board_model #(.HOLD(12)) board_u (
        .clk_in(clk_sys_in), .rst_req_in(rst_req), .code_in(code),
        .msel_in(msel), .fast_in(fast), .reset_n_out(reset_n_in),
        .core_clk_out(core_clock_in), .msel_out(pll_multiplier_select_in),
        .range_out(input_range_bit_in),
        .boot_pins_out({boot_select_bit2_in, boot_select_bit1_in,
                        boot_select_bit0_in}));
    clock_reset_boot_select #(.POR_HOLD(8)) dut_u (
        .clk_sys_in, .srst_in, .reset_n_in, .supply_low_in, .bypass_in,
        .pll_multiplier_select_in, .input_range_bit_in,
        .boot_select_bit2_in, .boot_select_bit1_in, .boot_select_bit0_in,
        .bus_request_in, .core_clock_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .por_n_out, .master_reset_out, .boot_irq_out,
        .boot_vector_out, .boot_mode_out, .boot_mode_bad_out,
        .pll_multiplier_select_out, .input_range_bit_out, .pll_bypass_out,
        .peripheral_clock_out_pin_out);

    // 50 MHz clock
    initial begin
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    // ==========================================================
    // Tasks
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1;
        chk(24'(rdata_out), 24'(exp));
    endtask

    // Bounded wait: boot interrupt (sel 0) or power-on release (sel 1)
    task automatic wait_for(input logic sel, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge clk_sys_in);
            #1;
            if ((sel ? por_n_out : boot_irq_out) === 1'b1)
                break;
        end
        n_compared++;
        if (i == lim) begin
            num_errors++;
            $display("[ERR] t=%0t got=0 exp=1", $time);
            report_and_stop();
        end
    endtask

    // Strap a boot code and run a board reset frame
    task automatic hw_reset(input logic [2:0] c);
        @(posedge clk_sys_in);
        code      <= c;
        msel      <= {c, 4'h9};
        fast      <= c[0];
        bypass_in <= c[1];
        rst_req   <= 1'b1;
        @(posedge clk_sys_in);
        rst_req <= 1'b0;
    endtask

    // Count pin toggles over 16 cycles
    task automatic pin_rate(input int exp);
        int   n;
        logic p;
        repeat (4) @(posedge clk_sys_in);
        #1;
        n = 0;
        p = peripheral_clock_out_pin_out;
        repeat (16) begin
            @(posedge clk_sys_in);
            #1;
            n += int'(peripheral_clock_out_pin_out !== p);
            p = peripheral_clock_out_pin_out;
        end
        chk(24'(n), 24'(exp));
    endtask

    task automatic report_and_stop();
        $display("compares=%0d errors=%0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Sequence
    initial begin
        repeat (5) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        wait_for(1'b0, 40);
        wait_for(1'b1, 40);
        rd_chk(4'h0, 16'h0000);
        rd_chk(4'h1, 16'h0008);
        rd_chk(4'h3, 16'h0005);
        rd_chk(4'hF, 16'h0000);
        $display("test reset_defaults done");
        for (int c = 0; c < 8; c++) begin
            hw_reset(3'(c));
            wait_for(1'b0, 60);
            chk(boot_vector_out, 24'hFF0000);
            chk(24'(boot_mode_out), 24'(c));
            chk(24'(boot_mode_bad_out), 24'(c == 0 || c > 5));
            chk(24'(pll_multiplier_select_out), 24'(c * 16 + 9));
            chk(24'({pll_bypass_out, input_range_bit_out}), 24'(c & 3));
            rd_chk(4'h1, 16'({c == 0 || c > 5, 3'(c)}));
        end
        $display("test boot_codes done");
        code <= 3'h2;
        repeat (8) @(posedge clk_sys_in);
        chk(24'(boot_mode_out), 24'h7);
        wr(4'h2, 16'h00A5);
        wait_for(1'b0, 20);
        chk(24'(boot_mode_out), 24'h7);
        $display("test soft_reset done");
        bus_request_in <= 1'b1;
        hw_reset(3'h4);
        repeat (40) begin
            @(posedge clk_sys_in);
            #1;
            chk(24'(boot_irq_out), 24'h0);
        end
        chk(24'(master_reset_out), 24'h1);
        bus_request_in <= 1'b0;
        wait_for(1'b0, 20);
        $display("test bus_request done");
        wr(4'h0, 16'h0205);
        rd_chk(4'h0, 16'h0205);
        pin_rate(8);
        wr(4'h0, 16'h0005);
        pin_rate(16);
        $display("test clock_out done");
        supply_low_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        #1;
        chk(24'(por_n_out), 24'h0);
        supply_low_in <= 1'b0;
        wait_for(1'b1, 40);
        $display("test brownout done");
        report_and_stop();
    end
endmodule
